/* File: pkg/sdc_pkg.sv */
package sdc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CODE_MSB_POS = 11;
  localparam logic [4:0] LAST_EDGE = 5'h10;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PD_1K = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_HIZ = 2'h3;
  localparam int SYNC_HIGH_NS = 33;
  localparam int CLOCK_NS = 100;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [11:0] ADDR_CODE = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_SHIFT = 3'b010,
    FR_DONE = 3'b100
  } sdc_frame_t;
endpackage : sdc_pkg

/* File: design/sdc_sync2.sv */
`timescale 1ns/1ps
module sdc_sync2 (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_reg;

  // Two stages; only the second stage is read so metastability settles first.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule : sdc_sync2

/* File: design/sdc_serial_dac_ctrl.sv */
`timescale 1ns/1ps
module sdc_serial_dac_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic frameSelN,
  input wire logic serialClk,
  input wire logic serialData,
  output logic [11:0] dacCode,
  output logic [1:0] powerMode,
  output logic ampConnect,
  output logic pulldown1k,
  output logic pulldown100k,
  output logic outputHiZ,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic selN;
  logic sclk;
  logic sdat;
  logic selPrev_reg;
  logic sclkPrev_reg;
  sdc_pkg::sdc_frame_t frame_reg;
  logic [15:0] shift_reg;
  logic [4:0] edgeCount_reg;
  logic [11:0] code_reg;
  logic [1:0] mode_reg;
  logic [15:0] frameCount_reg;
  logic abortSeen_reg;
  logic [15:0] frameWord;
  logic awHeld_reg;
  logic wHeld_reg;
  logic [11:0] awAddr_reg;

  sdc_sync2 uSel (.clock(clock), .sys_rst(sys_rst), .asyncIn(frameSelN), .syncOut(selN));
  sdc_sync2 uClk (.clock(clock), .sys_rst(sys_rst), .asyncIn(serialClk), .syncOut(sclk));
  sdc_sync2 uDat (.clock(clock), .sys_rst(sys_rst), .asyncIn(serialData), .syncOut(sdat));

  wire selFall = selPrev_reg && !selN;
  wire clkFall = sclkPrev_reg && !sclk;
  // Data was synchronised alongside the clock, so it is sampled with the same delay.
  assign frameWord = {shift_reg[14:0], sdat};

  // Previous synchronised levels for edge detection.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      selPrev_reg <= 1'b1;
      sclkPrev_reg <= 1'b1;
    end else begin
      selPrev_reg <= selN;
      sclkPrev_reg <= sclk;
    end
  end

  // Frame sequencer; the host's 33 ns high time is far below one sample period,
  // so a shorter pulse may be missed entirely.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_reg <= sdc_pkg::FR_IDLE;
      shift_reg <= 16'h0000;
      edgeCount_reg <= 5'h00;
    end else begin
      case (frame_reg)
        sdc_pkg::FR_IDLE: begin
          if (selFall) begin
            frame_reg <= sdc_pkg::FR_SHIFT;
            shift_reg <= 16'h0000;
            edgeCount_reg <= 5'h00;
          end
        end
        sdc_pkg::FR_SHIFT: begin
          if (selN) begin
            frame_reg <= sdc_pkg::FR_IDLE;
            shift_reg <= 16'h0000;
            edgeCount_reg <= 5'h00;
          end else if (clkFall) begin
            shift_reg <= frameWord;
            edgeCount_reg <= edgeCount_reg + 5'h01;
            if (edgeCount_reg + 5'h01 == sdc_pkg::LAST_EDGE) begin
              frame_reg <= sdc_pkg::FR_DONE;
            end
          end
        end
        sdc_pkg::FR_DONE: begin
          if (selN) begin
            frame_reg <= sdc_pkg::FR_IDLE;
            edgeCount_reg <= 5'h00;
          end
        end
        default: begin
          frame_reg <= sdc_pkg::FR_IDLE;
        end
      endcase
    end
  end

  wire frameLoad = (frame_reg == sdc_pkg::FR_SHIFT) && !selN && clkFall &&
                   (edgeCount_reg + 5'h01 == sdc_pkg::LAST_EDGE);

  // Code and mode change only on a complete frame; reset gives zero volts.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      code_reg <= sdc_pkg::CODE_RESET;
      mode_reg <= sdc_pkg::MODE_RESET;
    end else if (frameLoad) begin
      code_reg <= frameWord[sdc_pkg::CODE_MSB_POS:0];
      mode_reg <= {frameWord[sdc_pkg::MODE_HI_POS], frameWord[sdc_pkg::MODE_LO_POS]};
    end
  end

  // Frame statistics for software.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frameCount_reg <= 16'h0000;
      abortSeen_reg <= 1'b0;
    end else begin
      if (frameLoad) begin
        frameCount_reg <= frameCount_reg + 16'h0001;
      end
      if (frame_reg == sdc_pkg::FR_SHIFT && selN) begin
        abortSeen_reg <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready && awAddr_reg == sdc_pkg::ADDR_STATUS) begin
        abortSeen_reg <= 1'b0;
      end
    end
  end

  // Output stage switching decoded from the mode.
  always_comb begin
    ampConnect = 1'b0;
    pulldown1k = 1'b0;
    pulldown100k = 1'b0;
    outputHiZ = 1'b0;
    case (mode_reg)
      sdc_pkg::MODE_NORMAL: ampConnect = 1'b1;
      sdc_pkg::MODE_PD_1K: pulldown1k = 1'b1;
      sdc_pkg::MODE_PD_100K: pulldown100k = 1'b1;
      sdc_pkg::MODE_HIZ: outputHiZ = 1'b1;
      default: outputHiZ = 1'b1;
    endcase
  end
  assign dacCode = code_reg;
  assign powerMode = mode_reg;

  // AXI write: address and data captured in either order, then one response.
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 12'h000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_reg == sdc_pkg::ADDR_STATUS) ? sdc_pkg::RESP_OKAY : sdc_pkg::RESP_SLVERR;
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read of the held code, mode and frame status.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sdc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sdc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sdc_pkg::ADDR_CODE: s_axi_rdata <= {20'h00000, code_reg};
        sdc_pkg::ADDR_MODE: s_axi_rdata <= {30'h0, mode_reg};
        sdc_pkg::ADDR_STATUS: s_axi_rdata <= {15'h0, abortSeen_reg, frameCount_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= sdc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on frame handling and output routing.
  a_abort_keeps_code: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_reg == sdc_pkg::FR_SHIFT && selN) |=> $stable(code_reg) && $stable(mode_reg))
    else $error("Code changed on aborted frame.");
  a_abort_clears_shift: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_reg == sdc_pkg::FR_SHIFT && selN) |=> shift_reg == 16'h0000 && frame_reg == sdc_pkg::FR_IDLE)
    else $error("Shift register not cleared on abort.");
  a_load_code_value: assert property (@(posedge clock) disable iff (sys_rst)
    frameLoad |=> code_reg == $past(frameWord[11:0]))
    else $error("Code not loaded from frame.");
  a_load_mode_value: assert property (@(posedge clock) disable iff (sys_rst)
    frameLoad |=> mode_reg == $past(frameWord[13:12]))
    else $error("Mode not loaded from frame bits.");
  a_change_needs_load: assert property (@(posedge clock) disable iff (sys_rst)
    !frameLoad |=> $stable(code_reg))
    else $error("Code changed without a complete frame.");
  a_sixteen_edges: assert property (@(posedge clock) disable iff (sys_rst)
    frameLoad |-> edgeCount_reg == 5'h0F)
    else $error("Load not on sixteenth edge.");
  a_done_ignores: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_reg == sdc_pkg::FR_DONE && !selN) |=> frame_reg == sdc_pkg::FR_DONE && $stable(shift_reg))
    else $error("Edges accepted after frame end.");
  a_start_on_fall: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_reg == sdc_pkg::FR_IDLE && !selFall) |=> frame_reg == sdc_pkg::FR_IDLE)
    else $error("Frame started without select fall.");
  a_amp_normal_only: assert property (@(posedge clock) disable iff (sys_rst)
    ampConnect == (mode_reg == sdc_pkg::MODE_NORMAL) && (pulldown1k == (mode_reg == sdc_pkg::MODE_PD_1K)) &&
    (pulldown100k == (mode_reg == sdc_pkg::MODE_PD_100K)) && (outputHiZ == (mode_reg == sdc_pkg::MODE_HIZ)))
    else $error("Output routing disagrees with mode.");
  c_frame_loaded: cover property (@(posedge clock) disable iff (sys_rst) frameLoad);
  c_frame_aborted: cover property (@(posedge clock) disable iff (sys_rst) frame_reg == sdc_pkg::FR_SHIFT && selN);
  c_hiz_mode: cover property (@(posedge clock) disable iff (sys_rst) outputHiZ);
endmodule : sdc_serial_dac_ctrl

/* File: verif/sdc_host_model.sv */
`timescale 1ns/1ps
// Host end of the link; the serial clock idles high and stands still between frames.
module sdc_host_model (
  output logic frameSelN,
  output logic serialClk,
  output logic serialData
);
  // Idle levels before the first frame.
  initial begin
    frameSelN = 1'b1;
    serialClk = 1'b1;
    serialData = 1'b0;
  end
  // Sends n frame bits, then extra clock falls, then releases select.
  task send(input logic [15:0] frame, input int n, input int extra);
    int i;
    // Pins move by non-blocking assignment so the synchronisers never race the bench.
    frameSelN <= 1'b0;
    for (i = 0; i < n + extra; i++) begin
      serialData <= (i < 16) ? frame[15 - i] : i[0];
      #400 serialClk <= 1'b0;
      #400 serialClk <= 1'b1;
    end
    frameSelN <= 1'b1;
    serialData <= ~serialData;
    #1200;
  endtask : send
endmodule : sdc_host_model

/* File: verif/serial_dac_input_control_test.sv */
`timescale 1ns/1ps
module serial_dac_input_control_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic frameSelN, serialClk, serialData, ampConnect, pulldown1k, pulldown100k, outputHiZ;
  logic [11:0] dacCode, awaddr = 12'h000, araddr = 12'h000;
  logic [1:0] powerMode, bresp, rresp, resp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ta, tw;
  logic [31:0] wdata = 32'h0000_0000, rdata, val;
  logic [11:0] codes [4] = '{12'hFFF, 12'h001, 12'h800, 12'h7FE};
  int errors = 0;
  int tests_run = 0;
  // Half period of a 100 ns clock.
  always #50 clock = ~clock;
  sdc_serial_dac_ctrl sdc_serial_dac_ctrl_inst (.clock(clock), .sys_rst(sys_rst), .frameSelN(frameSelN),
    .serialClk(serialClk), .serialData(serialData), .dacCode(dacCode), .powerMode(powerMode),
    .ampConnect(ampConnect), .pulldown1k(pulldown1k), .pulldown100k(pulldown100k), .outputHiZ(outputHiZ),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sdc_host_model sdc_host_model_inst (.frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // Readies are sampled at the falling edge, so the rising edge sees settled values.
  task axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock);
      ta = awready && awvalid;
      tw = wready && wvalid;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && !wvalid || tw && !awvalid || ta && tw));
    do @(negedge clock); while (!bvalid);
    r = bresp;
    @(posedge clock);
    bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 1'b0;
    do @(negedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clock);
    rready <= 1'b0;
  endtask : axi_read
  // A complete frame with both ignored bits set, then outputs and registers.
  task frame_check(input logic [1:0] m, input logic [11:0] c);
    sdc_host_model_inst.send({2'h3, m, c}, 16, 0);
    check("code", {20'h0, dacCode}, {20'h0, c});
    check("mode", {30'h0, powerMode}, {30'h0, m});
    check("route", {ampConnect, pulldown1k, pulldown100k, outputHiZ}, 4'h8 >> m);
    axi_read(sdc_pkg::ADDR_CODE, val, resp);
    check("code reg", val, {20'h0, c});
    axi_read(sdc_pkg::ADDR_MODE, val, resp);
    check("mode reg", val, {30'h0, m});
  endtask : frame_check
  // Limit well above the longest expected run.
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check("reset code", {20'h0, dacCode}, 32'h0000_0000);
    check("reset route", {ampConnect, pulldown1k, pulldown100k, outputHiZ}, 4'h8);
    for (int m = 0; m < 4; m++) frame_check(m[1:0], codes[m]);
    sdc_host_model_inst.send({2'h0, 2'h1, 12'h123}, 15, 0);
    check("abort code", {20'h0, dacCode}, 32'h0000_07FE);
    check("abort mode", {30'h0, powerMode}, 32'h0000_0003);
    axi_read(sdc_pkg::ADDR_STATUS, val, resp);
    check("abort flag", {31'h0, val[16]}, 32'h0000_0001);
    axi_write(sdc_pkg::ADDR_STATUS, 32'h0000_0000, resp);
    check("clear resp", {30'h0, resp}, {30'h0, sdc_pkg::RESP_OKAY});
    axi_read(sdc_pkg::ADDR_STATUS, val, resp);
    check("flag cleared", {31'h0, val[16]}, 32'h0000_0000);
    sdc_host_model_inst.send({2'h0, 2'h0, 12'hC3A}, 16, 4);
    check("extra edges", {20'h0, dacCode}, 32'h0000_0C3A);
    axi_read(sdc_pkg::ADDR_STATUS, val, resp);
    check("frame count", {16'h0, val[15:0]}, 32'h0000_0005);
    frame_check(2'h0, 12'h555);
    axi_write(sdc_pkg::ADDR_CODE, 32'h0000_0FFF, resp);
    check("ro write", {30'h0, resp}, {30'h0, sdc_pkg::RESP_SLVERR});
    axi_read(12'h00C, val, resp);
    check("unmapped resp", {30'h0, resp}, {30'h0, sdc_pkg::RESP_SLVERR});
    check("unmapped data", val, 32'h0000_0000);
    complete_run();
  end
endmodule : serial_dac_input_control_test
